// ==== core/eight_bit_waveform_timer_params.svh ====
`ifndef EIGHT_BIT_WAVEFORM_TIMER_PARAMS_SVH
`define EIGHT_BIT_WAVEFORM_TIMER_PARAMS_SVH

// ==========================================================
// Widths
`define WT_ADDR_W 8
`define WT_COUNT_W 8
`define WT_PRESCALE_W 10

// ==========================================================
// Register byte offsets
`define WT_OFS_CONTROL 8'h00
`define WT_OFS_COUNTER 8'h04
`define WT_OFS_COMPARE 8'h08
`define WT_OFS_FLAGS 8'h0c

// ==========================================================
// Control register fields and reset values
`define WT_BIT_FORCE 7
`define WT_BIT_WAVE_HI 6
`define WT_BIT_COM_HI 5
`define WT_BIT_COM_LO 4
`define WT_BIT_WAVE_LO 3
`define WT_BIT_CS_HI 2
`define WT_CONTROL_RESET 7'h00
`define WT_COUNTER_RESET 8'h00
`define WT_COMPARE_RESET 8'h00

// ==========================================================
// Flag register fields
`define WT_BIT_MATCH_FLAG 1
`define WT_BIT_OVF_FLAG 0

// ==========================================================
// Clock select codes
`define WT_CS_DIV1 3'h1
`define WT_CS_DIV8 3'h2
`define WT_CS_DIV64 3'h3
`define WT_CS_DIV256 3'h4
`define WT_CS_DIV1024 3'h5

// ==========================================================
// Output action codes and count limits
`define WT_COM_OFF 2'h0
`define WT_COM_TOGGLE 2'h1
`define WT_COM_CLEAR 2'h2
`define WT_COM_SET 2'h3
`define WT_BOTTOM 8'h00
`define WT_BOTTOM_PLUS1 8'h01
`define WT_MAX_LESS1 8'hfe
`define WT_MAX 8'hff

`endif

// ==== core/waveform_timer_pkg.sv ====
package waveform_timer_pkg;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_PHASE = 2'h1,
    MODE_MATCH_CLEAR = 2'h2,
    MODE_FAST = 2'h3
  } waveMode_t;

  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } countDir_t;

endpackage : waveform_timer_pkg

// ==== core/tick_prescaler.sv ====
`timescale 1ns/100ps
`include "eight_bit_waveform_timer_params.svh"

module tick_prescaler
#(
  parameter int DIV_W = `WT_PRESCALE_W
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [2:0] clockSelect,
  output logic tick
);

  logic [DIV_W-1:0] divCount;
  logic due;

  if (DIV_W < 10)
  begin : g_bad_width
    $error("tick_prescaler needs DIV_W of at least 10");
  end

  // ==========================================================
  // Free-running divider, never reset by select changes
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      divCount <= '0;
    else
      divCount <= divCount + 1'b1;
  end

  always_comb
  begin
    case (clockSelect)
      `WT_CS_DIV1: due = 1'b1;
      `WT_CS_DIV8: due = &divCount[2:0];
      `WT_CS_DIV64: due = &divCount[5:0];
      `WT_CS_DIV256: due = &divCount[7:0];
      `WT_CS_DIV1024: due = &divCount[9:0];
      // Stopped; external pin sources are not wired to this block
      default: due = 1'b0;
    endcase
  end

  // Single-cycle enable, never a derived clock
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      tick <= 1'b0;
    else
      tick <= due;
  end

  chk_div8_spacing: assert property (
    @(posedge sys_clk) disable iff (rst)
    tick && clockSelect == `WT_CS_DIV8 |=>
      (!tick || clockSelect != `WT_CS_DIV8) [*7])
    else $error("div8 ticks closer than eight cycles");

endmodule : tick_prescaler

// ==== core/compare_output_unit.sv ====
`timescale 1ns/100ps
`include "eight_bit_waveform_timer_params.svh"

module compare_output_unit
  import waveform_timer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input waveMode_t mode,
  input wire logic [1:0] actionSelect,
  input wire logic match,
  input wire logic countUp,
  input wire logic atTop,
  input wire logic atBottom,
  input wire logic nextIsMax,
  input wire logic nextIsZero,
  input wire logic forceStrobe,
  output logic level,
  output logic enable
);

  logic upResult;
  logic downResult;

  function automatic logic applyAction(input logic cur,
                                       input logic [1:0] com);
    case (com)
      `WT_COM_TOGGLE: applyAction = ~cur;
      `WT_COM_CLEAR: applyAction = 1'b0;
      `WT_COM_SET: applyAction = 1'b1;
      default: applyAction = cur;
    endcase
  endfunction : applyAction

  assign upResult = actionSelect[0];
  assign downResult = ~actionSelect[0];

  // ==========================================================
  // Output level
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      level <= 1'b0;
    else if (forceStrobe && !mode[0])
      level <= applyAction(level, actionSelect);
    else if (actionSelect != `WT_COM_OFF)
    begin
      case (mode)
        MODE_FAST:
        begin
          // Bottom wins for clear and set, so a match at MAX shows only in toggle
          if (actionSelect[1] && atBottom)
            level <= ~actionSelect[0];
          else if (match)
            level <= actionSelect[1] ? actionSelect[0] : ~level;
        end
        MODE_PHASE:
        begin
          if (!actionSelect[1])
            level <= level;
          else if (atTop)
            level <= nextIsMax ? downResult : upResult;
          else if (atBottom)
            level <= nextIsZero ? upResult : downResult;
          else if (match)
            level <= countUp ? upResult : downResult;
        end
        default:
        begin
          if (match)
            level <= applyAction(level, actionSelect);
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      enable <= 1'b0;
    else
      enable <= actionSelect != `WT_COM_OFF;
  end

  chk_off_holds_level: assert property (
    @(posedge sys_clk) disable iff (rst)
    actionSelect == `WT_COM_OFF && !forceStrobe |=> $stable(level))
    else $error("output moved with action select off");

  chk_toggle_on_match: assert property (
    @(posedge sys_clk) disable iff (rst)
    mode == MODE_FAST && actionSelect == `WT_COM_TOGGLE && match
      |=> level != $past(level))
    else $error("fast mode toggle missed a match");

  chk_phase_up_clear: assert property (
    @(posedge sys_clk) disable iff (rst)
    mode == MODE_PHASE && actionSelect == `WT_COM_CLEAR && match &&
      countUp && !atTop && !atBottom && !forceStrobe |=> !level)
    else $error("up-counting match did not clear output");

  chk_fast_match_clear: assert property (
    @(posedge sys_clk) disable iff (rst)
    mode == MODE_FAST && actionSelect == `WT_COM_CLEAR && match &&
      !atBottom |=> !level)
    else $error("fast mode match did not clear output");

endmodule : compare_output_unit

// ==== core/eight_bit_waveform_timer.sv ====
// Chosen here: the address map and the APB register port.
`timescale 1ns/100ps
`include "eight_bit_waveform_timer_params.svh"

// What this block does
// - Tick is clock divided by 1/8/64/256/1024
// - Fast PWM period is 256 ticks
// - Fast PWM, compare at bottom: one-tick spike
// - Fast PWM, compare at max: constant level
// - Fast PWM toggle action gives half duty
// - Phase mode counts up then down repeatedly
// - Phase mode: up match and down match opposite
// - Phase mode holds max one tick, reverses
// - Phase mode sets overflow flag at bottom
// - Phase mode period is 510 ticks
// - Phase mode extremes give constant levels
// - Leaving max: top level equals up-match result unless next compare is max
// - Missed up match still applied at top
// - Counter synchronous; tick only enables updates
// - Force strobe applies match in non-PWM modes
// - Force sets no flag, clears no counter
// - Force bit always reads zero
// - Mode bits sit at control bits 6 and 3
// - Top and overflow point follow the mode
// - Compare update point follows the mode
// - Action zero disconnects pin, no action
module eight_bit_waveform_timer
  import waveform_timer_pkg::*;
#(
  parameter int COUNT_W = `WT_COUNT_W,
  parameter int ADDR_W = `WT_ADDR_W
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic compareOutputPin,
  output logic compareOutputEnable
);

  // ==========================================================
  // Elaboration checks
  if (COUNT_W != 8)
  begin : g_bad_count
    $error("counter is fixed at eight bits");
  end
  if (ADDR_W < 4)
  begin : g_bad_addr
    $error("address too narrow for the register map");
  end

  // ==========================================================
  // Declarations
  logic [6:0] control;
  logic [7:0] counterValue;
  logic [7:0] compareActive;
  logic [7:0] compareBuffer;
  logic [7:0] nextCompare;
  logic overflowFlag;
  logic compareMatchFlag;
  logic matchBlocked;
  logic forcePulse;
  logic tick;
  countDir_t countDir;
  waveMode_t mode;
  logic [1:0] actionSelect;
  logic pwmMode;
  logic accessPhase;
  logic writeDone;
  logic wrControl;
  logic wrCounter;
  logic wrCompare;
  logic wrFlags;
  logic mapped;
  logic isTop;
  logic isBottom;
  logic match;
  logic pcTurnTop;
  logic pcTurnBottom;
  logic wrapMax;
  logic bottomEvent;
  logic compareLoad;
  logic [7:0] readValue;

  function automatic logic addrHit(input logic [ADDR_W-1:0] addr,
                                   input logic [7:0] offset);
    addrHit = addr == ADDR_W'(offset);
  endfunction : addrHit

  // ==========================================================
  // Field decode
  assign mode = waveMode_t'({control[`WT_BIT_WAVE_HI],
                             control[`WT_BIT_WAVE_LO]});
  assign actionSelect = control[`WT_BIT_COM_HI:`WT_BIT_COM_LO];
  assign pwmMode = control[`WT_BIT_WAVE_LO];

  // ==========================================================
  // APB slave: one wait state, then pready for one cycle
  assign accessPhase = psel && penable;
  assign writeDone = accessPhase && pready && pwrite;
  assign wrControl = writeDone && addrHit(paddr, `WT_OFS_CONTROL);
  assign wrCounter = writeDone && addrHit(paddr, `WT_OFS_COUNTER);
  assign wrCompare = writeDone && addrHit(paddr, `WT_OFS_COMPARE);
  assign wrFlags = writeDone && addrHit(paddr, `WT_OFS_FLAGS);
  assign mapped = addrHit(paddr, `WT_OFS_CONTROL) ||
                  addrHit(paddr, `WT_OFS_COUNTER) ||
                  addrHit(paddr, `WT_OFS_COMPARE) ||
                  addrHit(paddr, `WT_OFS_FLAGS);

  always_comb
  begin
    readValue = 8'h00;
    if (addrHit(paddr, `WT_OFS_CONTROL))
      readValue = {1'b0, control};
    else if (addrHit(paddr, `WT_OFS_COUNTER))
      readValue = counterValue;
    else if (addrHit(paddr, `WT_OFS_COMPARE))
      readValue = compareBuffer;
    else if (addrHit(paddr, `WT_OFS_FLAGS))
      readValue = {6'h00, compareMatchFlag, overflowFlag};
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= accessPhase && !pready;
      pslverr <= accessPhase && !pready && !mapped;
      if (accessPhase && !pready && !pwrite)
        prdata <= {24'h00_0000, readValue};
    end
  end

  // ==========================================================
  // Control register; force bit is a strobe and is not stored
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      control <= `WT_CONTROL_RESET;
    else if (wrControl)
      control <= pwdata[6:0];
  end

  // Ignored in PWM; software keeps it zero there anyway
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      forcePulse <= 1'b0;
    else
      forcePulse <= wrControl && pwdata[`WT_BIT_FORCE] &&
                    !pwdata[`WT_BIT_WAVE_LO];
  end

  // ==========================================================
  // Prescaler
  tick_prescaler #(
    .DIV_W(`WT_PRESCALE_W)
  ) u_prescaler (
    .sys_clk(sys_clk),
    .rst(rst),
    .clockSelect(control[`WT_BIT_CS_HI:0]),
    .tick(tick)
  );

  // ==========================================================
  // Count events; all but isTop and isBottom qualified by the tick enable
  assign isTop = counterValue == `WT_MAX;
  assign isBottom = counterValue == `WT_BOTTOM;
  // A bus write to the counter hides the next match
  assign match = tick && counterValue == compareActive &&
                 !matchBlocked;
  assign pcTurnTop = tick && mode == MODE_PHASE &&
                     countDir == DIR_UP && isTop;
  assign pcTurnBottom = tick && mode == MODE_PHASE &&
                        countDir == DIR_DOWN && isBottom;
  assign wrapMax = tick && mode != MODE_PHASE && isTop;
  assign bottomEvent = mode == MODE_PHASE ? pcTurnBottom :
                       wrapMax && mode == MODE_FAST;
  assign compareLoad = (mode == MODE_PHASE && pcTurnTop) ||
                       (mode == MODE_FAST && wrapMax);
  assign nextCompare = compareLoad ? compareBuffer : compareActive;

  // ==========================================================
  // Counter
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      counterValue <= `WT_COUNTER_RESET;
    else if (wrCounter)
      counterValue <= pwdata[7:0];
    else if (tick)
    begin
      case (mode)
        MODE_PHASE:
        begin
          if (countDir == DIR_UP)
            counterValue <= isTop ? `WT_MAX_LESS1 :
                            counterValue + 8'h01;
          else
            counterValue <= isBottom ? `WT_BOTTOM_PLUS1 :
                            counterValue - 8'h01;
        end
        MODE_MATCH_CLEAR:
          counterValue <= match ? `WT_BOTTOM :
                          counterValue + 8'h01;
        default:
          counterValue <= counterValue + 8'h01;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      countDir <= DIR_UP;
    else if (mode != MODE_PHASE)
      countDir <= DIR_UP;
    else if (pcTurnTop)
      countDir <= DIR_DOWN;
    else if (pcTurnBottom)
      countDir <= DIR_UP;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      matchBlocked <= 1'b0;
    else if (wrCounter)
      matchBlocked <= 1'b1;
    else if (tick)
      matchBlocked <= 1'b0;
  end

  // ==========================================================
  // Compare value: immediate or double buffered
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      compareBuffer <= `WT_COMPARE_RESET;
    else if (wrCompare)
      compareBuffer <= pwdata[7:0];
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      compareActive <= `WT_COMPARE_RESET;
    else if (!pwmMode && wrCompare)
      compareActive <= pwdata[7:0];
    else if (!pwmMode)
      compareActive <= compareBuffer;
    else if (compareLoad)
      compareActive <= compareBuffer;
  end

  // ==========================================================
  // Flags: write one clears, a same-cycle set wins
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      overflowFlag <= 1'b0;
    else if (wrapMax || pcTurnBottom)
      overflowFlag <= 1'b1;
    else if (wrFlags && pwdata[`WT_BIT_OVF_FLAG])
      overflowFlag <= 1'b0;
  end

  // Forced compares never reach this flag
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      compareMatchFlag <= 1'b0;
    else if (match)
      compareMatchFlag <= 1'b1;
    else if (wrFlags && pwdata[`WT_BIT_MATCH_FLAG])
      compareMatchFlag <= 1'b0;
  end

  // ==========================================================
  // Output unit
  compare_output_unit u_output (
    .sys_clk(sys_clk),
    .rst(rst),
    .mode(mode),
    .actionSelect(actionSelect),
    .match(match),
    .countUp(countDir == DIR_UP),
    .atTop(pcTurnTop),
    .atBottom(bottomEvent),
    .nextIsMax(nextCompare == `WT_MAX),
    .nextIsZero(nextCompare == `WT_BOTTOM),
    .forceStrobe(forcePulse),
    .level(compareOutputPin),
    .enable(compareOutputEnable)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  chk_force_reads_zero: assert property (
    pready && !pwrite && $past(addrHit(paddr, `WT_OFS_CONTROL))
      |-> prdata[`WT_BIT_FORCE] == 1'b0)
    else $error("force bit read back as one");

  chk_phase_top_turn: assert property (
    pcTurnTop && !wrCounter |=> counterValue == `WT_MAX_LESS1 &&
      countDir == DIR_DOWN)
    else $error("phase mode did not reverse after max");

  chk_phase_overflow: assert property (
    pcTurnBottom |=> overflowFlag && counterValue == `WT_BOTTOM_PLUS1
      || wrCounter)
    else $error("phase mode bottom did not set overflow");

  chk_match_clear: assert property (
    tick && mode == MODE_MATCH_CLEAR && counterValue == compareActive &&
      !matchBlocked && !wrCounter
      |=> counterValue == `WT_BOTTOM && compareMatchFlag)
    else $error("match mode did not clear and flag");

  chk_fast_wrap: assert property (
    tick && mode == MODE_FAST && isTop && !wrCounter
      |=> counterValue == `WT_BOTTOM && overflowFlag)
    else $error("fast mode did not wrap with overflow");

  chk_phase_max_high: assert property (
    pcTurnBottom && actionSelect == `WT_COM_CLEAR &&
      compareActive == `WT_MAX |=> compareOutputPin)
    else $error("phase mode max compare not high");

  chk_fast_zero_spike: assert property (
    wrapMax && mode == MODE_FAST && actionSelect == `WT_COM_CLEAR &&
      compareBuffer == `WT_BOTTOM && !wrCounter |=> compareOutputPin)
    else $error("fast mode zero compare spike did not rise");

  chk_force_no_flag: assert property (
    forcePulse && !match && !compareMatchFlag |=> !compareMatchFlag)
    else $error("forced compare set the match flag");

  chk_hold_between_ticks: assert property (
    !tick && !wrCounter |=> $stable(counterValue))
    else $error("counter moved without a tick");

  cov_fast_pwm: cover property (
    wrapMax && mode == MODE_FAST && actionSelect == `WT_COM_CLEAR);
  cov_phase_turn: cover property (pcTurnBottom ##[1:1000] pcTurnTop);
  cov_forced: cover property (forcePulse && mode == MODE_NORMAL);
  cov_match_clear: cover property (match && mode == MODE_MATCH_CLEAR);

endmodule : eight_bit_waveform_timer

// ==== dv/pin_load_model.sv ====
`timescale 1ns/100ps

// ==========================================================
// Load on the compare output pin
module pin_load_model
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pinLevel,
  input wire logic pinEnable,
  output logic [15:0] riseCount,
  output logic [15:0] lastPeriod,
  output logic [15:0] lastHigh
);
  logic loadLevel;
  logic prevLevel;
  logic [15:0] sinceRise;
  logic [15:0] highRun;

  // Pull-down on the load: a released pin reads low
  assign loadLevel = pinEnable ? pinLevel : 1'b0;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      prevLevel <= 1'b0;
      sinceRise <= 16'h0000;
      highRun <= 16'h0000;
      riseCount <= 16'h0000;
      lastPeriod <= 16'h0000;
      lastHigh <= 16'h0000;
    end
    else
    begin
      prevLevel <= loadLevel;
      sinceRise <= sinceRise + 16'h0001;
      highRun <= loadLevel ? highRun + 16'h0001 : 16'h0000;
      if (loadLevel && !prevLevel)
      begin
        riseCount <= riseCount + 16'h0001;
        lastPeriod <= sinceRise + 16'h0001;
        sinceRise <= 16'h0000;
      end
      if (!loadLevel && prevLevel)
        lastHigh <= highRun;
    end
  end
endmodule : pin_load_model

// ==== dv/eight_bit_waveform_timer_tb_top.sv ====
`timescale 1ns/100ps
`include "eight_bit_waveform_timer_params.svh"

module eight_bit_waveform_timer_tb_top;
  localparam logic [15:0] DIV_PERIOD [1:5] =
    '{16'h0002, 16'h0010, 16'h0080, 16'h0200, 16'h0800};
  logic sys_clk;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic compareOutputPin;
  logic compareOutputEnable;
  logic [15:0] riseCount;
  logic [15:0] lastPeriod;
  logic [15:0] lastHigh;
  int n_errors = 0;
  int cmp_count = 0;

  eight_bit_waveform_timer i_eight_bit_waveform_timer (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .compareOutputPin(compareOutputPin),
    .compareOutputEnable(compareOutputEnable));

  pin_load_model i_pin_load_model (
    .sys_clk(sys_clk), .rst(rst), .pinLevel(compareOutputPin),
    .pinEnable(compareOutputEnable), .riseCount(riseCount),
    .lastPeriod(lastPeriod), .lastHigh(lastHigh));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Verdict and checks
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // ==========================================================
  // Bus master, waits on pready under a bound
  task apbXfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
               output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20)
      check(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apbXfer

  task apbWrite(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apbXfer(1'b1, a, d, rd, err);
  endtask : apbWrite

  task readCheck(input logic [7:0] a, input logic [31:0] mask,
                 input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apbXfer(1'b0, a, 32'h0, rd, err);
    check(rd & mask, exp);
    check({31'h0, err}, {31'h0, a > 8'h0c});
  endtask : readCheck

  // ==========================================================
  // Waveform scenarios seen through the load
  task setup(input logic [7:0] ctrl, input logic [7:0] cmp);
    apbWrite(`WT_OFS_COMPARE, {24'h0, cmp});
    apbWrite(`WT_OFS_CONTROL, {24'h0, ctrl});
  endtask : setup

  task periodIs(input logic [7:0] ctrl, input logic [7:0] cmp,
                input logic [15:0] per);
    logic [15:0] start;
    int k;
    setup(ctrl, cmp);
    start = riseCount;
    k = 0;
    // Three rises: the first may still come from the old setting
    while (16'(riseCount - start) < 16'h0003 && k < 20000)
    begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 20000)
      check(32'h0, 32'h1);
    check({16'h0, lastPeriod}, {16'h0, per});
  endtask : periodIs

  task steady(input logic [7:0] ctrl, input logic [7:0] cmp,
              input logic lvl);
    logic [15:0] start;
    setup(ctrl, cmp);
    // New compare may load only at the next top turn of a dual slope
    repeat (600) @(posedge sys_clk);
    start = riseCount;
    // Window longer than one dual-slope period
    repeat (600) @(posedge sys_clk);
    check({16'h0, 16'(riseCount - start)}, 32'h0);
    check({31'h0, compareOutputPin}, {31'h0, lvl});
  endtask : steady

  task endTest(input string name);
    $display("test %s done, mismatches so far %0d", name, n_errors);
  endtask : endTest

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [7:0] forceCtrl [3];
    forceCtrl = '{8'hb0, 8'ha0, 8'h90};
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    readCheck(`WT_OFS_CONTROL, 32'hffffffff, 32'h0);
    readCheck(`WT_OFS_COUNTER, 32'hffffffff, 32'h0);
    readCheck(`WT_OFS_COMPARE, 32'hffffffff, 32'h0);
    readCheck(`WT_OFS_FLAGS, 32'hffffffff, 32'h0);
    readCheck(8'h10, 32'hffffffff, 32'h0);
    endTest("reset");

    for (int i = 1; i <= 5; i++)
      periodIs(8'h50 | 8'(i), 8'h00, DIV_PERIOD[i]);
    periodIs(8'h51, 8'h03, 16'h0008);
    readCheck(`WT_OFS_FLAGS, 32'h2, 32'h2);
    endTest("prescale_and_match_clear");

    apbWrite(`WT_OFS_CONTROL, 32'h69);
    readCheck(`WT_OFS_CONTROL, 32'hff, 32'h69);
    periodIs(8'h69, 8'h80, 16'h0100);
    check({16'h0, lastHigh}, 32'h81);
    periodIs(8'h69, 8'h00, 16'h0100);
    check({16'h0, lastHigh}, 32'h1);
    steady(8'h69, 8'hff, 1'b1);
    steady(8'h79, 8'hff, 1'b0);
    periodIs(8'h59, 8'h80, 16'h0200);
    check({16'h0, lastHigh}, 32'h100);
    endTest("fast_pwm");

    periodIs(8'h29, 8'h80, 16'h01fe);
    apbWrite(`WT_OFS_FLAGS, 32'h3);
    repeat (600) @(posedge sys_clk);
    readCheck(`WT_OFS_FLAGS, 32'h1, 32'h1);
    steady(8'h29, 8'h00, 1'b0);
    steady(8'h29, 8'hff, 1'b1);
    steady(8'h39, 8'h00, 1'b1);
    endTest("phase_pwm");

    apbWrite(`WT_OFS_CONTROL, 32'h49);
    repeat (4) @(posedge sys_clk);
    check({31'h0, compareOutputEnable}, 32'h0);
    endTest("disconnect");

    // Clock stopped so only the strobe can move the pin
    apbWrite(`WT_OFS_CONTROL, 32'h30);
    apbWrite(`WT_OFS_COUNTER, 32'h05);
    apbWrite(`WT_OFS_FLAGS, 32'h3);
    for (int i = 0; i < 3; i++)
    begin
      apbWrite(`WT_OFS_CONTROL, {24'h0, forceCtrl[i]});
      repeat (3) @(posedge sys_clk);
      check({31'h0, compareOutputPin}, {31'h0, i != 1});
    end
    readCheck(`WT_OFS_CONTROL, 32'hff, 32'h10);
    readCheck(`WT_OFS_FLAGS, 32'h3, 32'h0);
    readCheck(`WT_OFS_COUNTER, 32'hff, 32'h05);
    endTest("force_strobe");
    tally_and_finish();
  end

  initial
  begin
    repeat (80000) @(posedge sys_clk);
    n_errors++;
    $display("watchdog expired at %0t", $time);
    tally_and_finish();
  end
endmodule : eight_bit_waveform_timer_tb_top
